//--- pkg/meter_cfg_pkg.sv
// shared constants for the meter start-up and gain configuration block
`default_nettype none
package meter_cfg_pkg;
	localparam int ADDR_W = 10;
	localparam int DATA_W = 24;
	localparam logic [9:0] ADDR_VOLTAGE_GAIN = 10'h007;
	localparam logic [9:0] ADDR_CURRENT_A_GAIN = 10'h008;
	localparam logic [9:0] ADDR_CURRENT_B_GAIN = 10'h009;
	localparam logic [9:0] ADDR_UNLOCK_KEY = 10'h0FE;
	localparam logic [9:0] ADDR_TIMING_CFG = 10'h120;
	localparam logic [9:0] ADDR_IRQ_STATUS = 10'h22D;
	// controller's own register map
	localparam logic [3:0] HREG_ADDR = 4'h0;
	localparam logic [3:0] HREG_WDATA = 4'h1;
	localparam logic [3:0] HREG_CMD = 4'h2;
	localparam logic [3:0] HREG_STATUS = 4'h3;
	localparam logic [3:0] HREG_RDATA = 4'h4;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int CMD_INIT_BIT = 2;
	localparam logic [7:0] UNLOCK_KEY = 8'hAD;
	localparam logic [7:0] TIMING_OPTIMUM = 8'h30;
	localparam logic [2:0] GAIN_RESET = 3'h0;
	localparam logic [2:0] GAIN_MAX_A = 3'h5;
	localparam logic [2:0] GAIN_MAX_BV = 3'h4;
	localparam logic [7:0] TIMING_RESET = 8'h00;
	localparam int IRQ_RESET_BIT = 20;
	localparam int CLK_MHZ = 100;
	localparam int INACTIVE_MS = 26;
	localparam int ENABLE_MS = 40;
	localparam int HOST_WAIT_MS = 100;
	localparam int INACTIVE_CYCLES = INACTIVE_MS * 1000 * CLK_MHZ;
	localparam int ENABLE_CYCLES = ENABLE_MS * 1000 * CLK_MHZ;
	localparam int HOST_WAIT_CYCLES = HOST_WAIT_MS * 1000 * CLK_MHZ;
endpackage : meter_cfg_pkg
`default_nettype wire

//--- pkg/meter_reg_if.sv
// register link between host controller and meter device
`timescale 1ns/1ns
`default_nettype none
interface meter_reg_if;
	logic [9:0] addr;
	logic [23:0] wdata;
	logic wr;
	logic rd;
	logic [23:0] rdata;
	logic irq_n;
	modport device (input addr, input wdata, input wr, input rd, output rdata, output irq_n);
	modport host (output addr, output wdata, output wr, output rd, input rdata, input irq_n);
endinterface : meter_reg_if
`default_nettype wire

//--- hw/meter_device.sv
// meter device end: power-up sequencer, key-protected timing register, gain selects
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module meter_device import meter_cfg_pkg::*; #(
	parameter int INACTIVE_CNT = meter_cfg_pkg::INACTIVE_CYCLES,
	parameter int ENABLE_CNT = meter_cfg_pkg::ENABLE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic supply_ok,
	meter_reg_if.device bus,
	output logic ready,
	output logic [4:0] gain_a_factor,
	output logic [4:0] gain_b_factor,
	output logic [4:0] gain_v_factor,
	output logic [7:0] timing_cfg_out
);
	import meter_cfg_pkg::*;

	typedef enum logic [2:0] {
		ST_OFF = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN = 3'b100
	} seq_e;

	seq_e state;
	logic [31:0] count;
	logic supply_s1;
	logic supply_s2;
	logic irq_flag;
	logic key_ok;
	logic [2:0] gain_v;
	logic [2:0] gain_a;
	logic [2:0] gain_b;
	logic [7:0] timing_cfg;
	logic wr_ok;
	logic rd_ok;

	// supply monitor level synchroniser
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			supply_s1 <= 1'b0;
			supply_s2 <= 1'b0;
		end else begin
			supply_s1 <= supply_ok;
			supply_s2 <= supply_s1;
		end
	end

	// power-up sequencer, one counter over both phases
	// inactive then enable
	always_ff @(posedge sys_clk) begin
		if (srst || !supply_s2) begin
			state <= ST_OFF;
			count <= 32'h0;
		end else begin
			case (state)
				ST_OFF: begin
					if (count >= 32'(INACTIVE_CNT - 1)) begin
						state <= ST_WAIT;
						count <= 32'h0;
					end else begin
						count <= count + 32'h1;
					end
				end
				ST_WAIT: begin
					if (count >= 32'(ENABLE_CNT - 1)) begin
						state <= ST_RUN;
						count <= 32'h0;
					end else begin
						count <= count + 32'h1;
					end
				end
				ST_RUN: begin
					count <= 32'h0;
				end
				default: begin
					state <= ST_OFF;
					count <= 32'h0;
				end
			endcase
		end
	end

	// accesses are ignored until start-up completes
	assign wr_ok = bus.wr && (state == ST_RUN);
	assign rd_ok = bus.rd && (state == ST_RUN);

	// reset flag, clear on status read, set wins
	always_ff @(posedge sys_clk) begin
		if (srst || !supply_s2) begin
			irq_flag <= 1'b0;
		end else if (state == ST_WAIT && count >= 32'(ENABLE_CNT - 1)) begin
			irq_flag <= 1'b1;
		end else if (rd_ok && bus.addr == ADDR_IRQ_STATUS) begin
			irq_flag <= 1'b0;
		end
	end

	// key arms only the very next cycle
	// an idle cycle or any other write drops the key, so the pair must be back to back
	always_ff @(posedge sys_clk) begin
		if (srst || state != ST_RUN) begin
			key_ok <= 1'b0;
		end else begin
			key_ok <= wr_ok && (bus.addr == ADDR_UNLOCK_KEY) && (bus.wdata[7:0] == UNLOCK_KEY);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || state != ST_RUN) begin
			timing_cfg <= TIMING_RESET;
		end else if (wr_ok && key_ok && bus.addr == ADDR_TIMING_CFG) begin
			timing_cfg <= bus.wdata[7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst || state != ST_RUN) begin
			gain_v <= GAIN_RESET;
			gain_a <= GAIN_RESET;
			gain_b <= GAIN_RESET;
		end else if (wr_ok) begin
			if (bus.addr == ADDR_VOLTAGE_GAIN) gain_v <= bus.wdata[2:0];
			if (bus.addr == ADDR_CURRENT_A_GAIN) gain_a <= bus.wdata[2:0];
			if (bus.addr == ADDR_CURRENT_B_GAIN) gain_b <= bus.wdata[2:0];
		end
	end

	// decode to factor, undefined codes give unity
	function automatic logic [4:0] gain_factor(input logic [2:0] code, input logic [2:0] max_code);
		logic [4:0] f;
		f = 5'h01;
		if (code <= max_code) begin
			case (code)
				3'h0: f = 5'h01;
				3'h1: f = 5'h02;
				3'h2: f = 5'h04;
				3'h3: f = 5'h08;
				3'h4: f = 5'h10;
				3'h5: f = 5'h16;
				default: f = 5'h01;
			endcase
		end
		return f;
	endfunction : gain_factor

	// registered outputs toward the analog side
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			gain_a_factor <= 5'h01;
			gain_b_factor <= 5'h01;
			gain_v_factor <= 5'h01;
			timing_cfg_out <= TIMING_RESET;
			ready <= 1'b0;
		end else begin
			gain_a_factor <= gain_factor(gain_a, GAIN_MAX_A);
			gain_b_factor <= gain_factor(gain_b, GAIN_MAX_BV);
			gain_v_factor <= gain_factor(gain_v, GAIN_MAX_BV);
			timing_cfg_out <= timing_cfg;
			ready <= (state == ST_RUN);
		end
	end

	// read data one cycle after read strobe, unmapped reads zero
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bus.rdata <= 24'h0;
		end else if (rd_ok) begin
			case (bus.addr)
				ADDR_VOLTAGE_GAIN: bus.rdata <= {21'h0, gain_v};
				ADDR_CURRENT_A_GAIN: bus.rdata <= {21'h0, gain_a};
				ADDR_CURRENT_B_GAIN: bus.rdata <= {21'h0, gain_b};
				ADDR_TIMING_CFG: bus.rdata <= {16'h0, timing_cfg};
				ADDR_IRQ_STATUS: bus.rdata <= 24'(irq_flag) << IRQ_RESET_BIT;
				default: bus.rdata <= 24'h0;
			endcase
		end else begin
			bus.rdata <= 24'h0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bus.irq_n <= 1'b1;
		end else begin
			bus.irq_n <= ~irq_flag;
		end
	end
endmodule : meter_device
`default_nettype wire

//--- hw/meter_host.sv
// host controller end: drives register link from software command registers
`timescale 1ns/1ns
`default_nettype none
module meter_host import meter_cfg_pkg::*; #(
	parameter int WAIT_CNT = meter_cfg_pkg::HOST_WAIT_CYCLES
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [3:0] sw_addr,
	input wire logic [23:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [23:0] sw_rdata,
	meter_reg_if.host bus
);
	import meter_cfg_pkg::*;

	typedef enum logic [5:0] {
		H_WAIT = 6'b000001,
		H_IDLE = 6'b000010,
		H_KEY = 6'b000100,
		H_TIMING = 6'b001000,
		H_READ = 6'b010000,
		H_RDONE = 6'b100000
	} host_e;

	host_e state;
	logic [31:0] count;
	logic irq_s1;
	logic irq_s2;
	logic [9:0] tgt_addr;
	logic [23:0] tgt_wdata;
	logic [23:0] rd_value;
	logic pend_wr;
	logic pend_rd;
	logic pend_init;
	logic init_done;

	// interrupt pin synchroniser
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_s1 <= 1'b1;
			irq_s2 <= 1'b1;
		end else begin
			irq_s1 <= bus.irq_n;
			irq_s2 <= irq_s1;
		end
	end

	// software register writes and pending commands
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tgt_addr <= 10'h0;
			tgt_wdata <= 24'h0;
			pend_wr <= 1'b0;
			pend_rd <= 1'b0;
			pend_init <= 1'b0;
		end else begin
			if (sw_wr && sw_addr == HREG_ADDR) tgt_addr <= sw_wdata[9:0];
			if (sw_wr && sw_addr == HREG_WDATA) tgt_wdata <= sw_wdata;
			if (state == H_IDLE) begin
				pend_wr <= 1'b0;
				pend_rd <= 1'b0;
				pend_init <= 1'b0;
			end
			if (sw_wr && sw_addr == HREG_CMD) begin
				pend_wr <= sw_wdata[CMD_WRITE_BIT];
				pend_rd <= sw_wdata[CMD_READ_BIT];
				pend_init <= sw_wdata[CMD_INIT_BIT];
			end
		end
	end

	// link sequencer
	// gate first access on interrupt or timeout
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= H_WAIT;
			count <= 32'h0;
			bus.addr <= 10'h0;
			bus.wdata <= 24'h0;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			rd_value <= 24'h0;
			init_done <= 1'b0;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			case (state)
				H_WAIT: begin
					count <= count + 32'h1;
					if (!irq_s2 || count >= 32'(WAIT_CNT - 1)) begin
						state <= H_KEY;
					end
				end
				H_IDLE: begin
					if (pend_init) begin
						state <= H_KEY;
					end else if (pend_wr) begin
						bus.addr <= tgt_addr;
						bus.wdata <= tgt_wdata;
						bus.wr <= 1'b1;
					end else if (pend_rd) begin
						bus.addr <= tgt_addr;
						bus.rd <= 1'b1;
						state <= H_READ;
					end
				end
				H_KEY: begin
					bus.addr <= ADDR_UNLOCK_KEY;
					bus.wdata <= {16'h0, UNLOCK_KEY};
					bus.wr <= 1'b1;
					state <= H_TIMING;
				end
				H_TIMING: begin
					bus.addr <= ADDR_TIMING_CFG;
					bus.wdata <= {16'h0, TIMING_OPTIMUM};
					bus.wr <= 1'b1;
					init_done <= 1'b1;
					state <= H_IDLE;
				end
				H_READ: begin
					state <= H_RDONE;
				end
				H_RDONE: begin
					rd_value <= bus.rdata;
					state <= H_IDLE;
				end
				default: begin
					state <= H_WAIT;
				end
			endcase
		end
	end

	// software read port, data one cycle after strobe
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sw_rdata <= 24'h0;
		end else if (sw_rd) begin
			case (sw_addr)
				HREG_ADDR: sw_rdata <= {14'h0, tgt_addr};
				HREG_WDATA: sw_rdata <= tgt_wdata;
				HREG_STATUS: sw_rdata <= {21'h0, ~irq_s2, init_done, state == H_IDLE};
				HREG_RDATA: sw_rdata <= rd_value;
				default: sw_rdata <= 24'h0;
			endcase
		end else begin
			sw_rdata <= 24'h0;
		end
	end
endmodule : meter_host
`default_nettype wire

//--- verification/meter_link_assertions.sv
// link checks for the meter start-up and gain block
`timescale 1ns/1ns
`default_nettype none
module meter_link_assertions (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [9:0] addr,
	input wire logic [23:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [23:0] rdata,
	input wire logic irq_n,
	input wire logic ready,
	input wire logic [4:0] gain_a_factor,
	input wire logic [4:0] gain_b_factor,
	input wire logic [4:0] gain_v_factor,
	input wire logic [7:0] timing_cfg_out
);
	import meter_cfg_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// key write and protected write steps
	sequence key_wr;
		wr && addr == ADDR_UNLOCK_KEY && wdata[7:0] == UNLOCK_KEY;
	endsequence
	sequence cfg_wr;
		wr && addr == ADDR_TIMING_CFG;
	endsequence
	a_cfg_unlocked: assert property (
		key_wr ##1 (cfg_wr and wdata[7:0] == TIMING_OPTIMUM) |-> ##[1:2] timing_cfg_out == TIMING_OPTIMUM)
		else $error("keyed timing write lost");
	a_cfg_locked: assert property (
		!(wr && addr == ADDR_UNLOCK_KEY) ##1 (cfg_wr and wdata[7:0] != timing_cfg_out)
		|-> ##2 timing_cfg_out != $past(wdata[7:0], 2)) else $error("unkeyed timing write taken");
	a_rdata_slot: assert property (
		!$past(rd) |-> rdata == 24'h000000) else $error("read data outside its slot");
	a_irq_clear: assert property (
		rd && addr == ADDR_IRQ_STATUS && !irq_n |=> rdata[IRQ_RESET_BIT] ##[1:2] irq_n)
		else $error("status read did not clear");
	a_irq_cause: assert property (
		$rose(irq_n) |-> $past(rd, 2) || $past(rd, 3)) else $error("interrupt dropped unread");
	a_irq_ready: assert property (
		$rose(ready) |-> ##[0:3] !irq_n) else $error("no interrupt after start-up");
	a_gain_top: assert property (
		wr && ready && addr == ADDR_CURRENT_A_GAIN && wdata[2:0] == GAIN_MAX_A |-> ##[1:2] gain_a_factor == 5'h16)
		else $error("top gain code not decoded");
	a_gain_a_set: assert property (
		$onehot(gain_a_factor) || gain_a_factor == 5'h16) else $error("bad gain a factor");
	a_gain_bv_set: assert property (
		$onehot(gain_b_factor) && $onehot(gain_v_factor)) else $error("bad gain b or v factor");
endmodule : meter_link_assertions
`default_nettype wire

//--- verification/meter_startup_and_gain_config_tb.sv
// bench for the meter host and device joined over the register link
`timescale 1ns/1ns
`default_nettype none
module meter_startup_and_gain_config_tb;
	import meter_cfg_pkg::*;
	logic sys_clk = 1'b0;
	logic srst = 1'b1;
	logic supply_ok = 1'b0;
	logic [3:0] sw_addr = 4'h0;
	logic [23:0] sw_wdata = 24'h0, sw_rdata, rv;
	logic sw_wr = 1'b0, sw_rd = 1'b0, ready;
	logic [4:0] fa, fb, fv;
	logic [7:0] tcfg;
	logic [9:0] ga [3] = '{ADDR_CURRENT_A_GAIN, ADDR_CURRENT_B_GAIN, ADDR_VOLTAGE_GAIN};
	logic [2:0] gt [3] = '{GAIN_MAX_A, GAIN_MAX_BV, GAIN_MAX_BV};
	int failures = 0;
	int tests_run = 0;
	meter_reg_if link ();
	meter_device #(.INACTIVE_CNT(20), .ENABLE_CNT(30)) meter_device_i (.sys_clk(sys_clk), .srst(srst),
		.supply_ok(supply_ok), .bus(link.device), .ready(ready), .gain_a_factor(fa), .gain_b_factor(fb),
		.gain_v_factor(fv), .timing_cfg_out(tcfg));
	meter_host #(.WAIT_CNT(100)) meter_host_i (.sys_clk(sys_clk), .srst(srst), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(link.host));
	meter_link_assertions meter_link_assertions_i (.sys_clk(sys_clk), .srst(srst), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .irq_n(link.irq_n), .ready(ready),
		.gain_a_factor(fa), .gain_b_factor(fb), .gain_v_factor(fv), .timing_cfg_out(tcfg));
	// free-running 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one-cycle strobes on the software port
	task automatic hw(input logic [3:0] a, input logic [23:0] d);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge sys_clk);
		sw_wr <= 1'b0;
	endtask : hw
	task automatic hr(input logic [3:0] a);
		@(posedge sys_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge sys_clk);
		sw_rd <= 1'b0;
		#1;
		rv = sw_rdata;
	endtask : hr
	// bounded wait on a host status bit
	task automatic poll(input int b);
		int n;
		n = 0;
		do begin
			hr(HREG_STATUS);
			n++;
		end while (rv[b] !== 1'b1 && n < 200);
		if (rv[b] !== 1'b1) chk(24'(rv[b]), 24'h1);
	endtask : poll
	task automatic dw(input logic [9:0] a, input logic [23:0] d);
		hw(HREG_ADDR, 24'(a));
		hw(HREG_WDATA, d);
		hw(HREG_CMD, 24'h1);
		poll(0);
	endtask : dw
	task automatic dr(input logic [9:0] a);
		hw(HREG_ADDR, 24'(a));
		hw(HREG_CMD, 24'h2);
		poll(0);
		hr(HREG_RDATA);
	endtask : dr
	function automatic logic [4:0] fac(input logic [2:0] c, input logic [2:0] top);
		if (c > top) return 5'h01;
		if (c == 3'h5) return 5'h16;
		return 5'h01 << c;
	endfunction : fac
	// start-up delay, interrupt, host init
	task automatic startup(input int lo);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(24'(n >= lo && n <= lo + 8), 24'h1);
		chk(24'(tcfg), 24'h0);
		chk(24'(fa), 24'h1);
		repeat (2) @(posedge sys_clk);
		#1;
		chk(24'(link.irq_n), 24'h0);
		poll(1);
		chk(24'(rv[2]), 24'h1);
		// timing output lands one cycle after the status read that saw init done
		@(posedge sys_clk);
		#1;
		chk(24'(tcfg), 24'(TIMING_OPTIMUM));
		$display("start-up test done");
	endtask : startup
	initial begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		supply_ok <= 1'b1;
		startup(50);
		dr(ADDR_IRQ_STATUS);
		chk(24'(rv[IRQ_RESET_BIT]), 24'h1);
		chk(24'(link.irq_n), 24'h1);
		// every code on every channel
		for (int ch = 0; ch < 3; ch++) begin
			dr(ga[ch]);
			chk(rv, 24'h0);
			for (int c = 0; c < 8; c++) begin
				dw(ga[ch], 24'(c));
				dr(ga[ch]);
				chk(rv, 24'(c));
				chk(24'(ch == 0 ? fa : ch == 1 ? fb : fv), 24'(fac(3'(c), gt[ch])));
			end
		end
		$display("gain test done");
		// key lapses over idle cycles before an unrelated write, then a late write
		dw(ADDR_UNLOCK_KEY, 24'(UNLOCK_KEY));
		dw(ADDR_CURRENT_A_GAIN, 24'h5);
		dw(ADDR_TIMING_CFG, 24'h55);
		chk(24'(tcfg), 24'h30);
		dw(ADDR_UNLOCK_KEY, 24'(UNLOCK_KEY));
		dw(ADDR_TIMING_CFG, 24'h55);
		dr(ADDR_TIMING_CFG);
		chk(rv, 24'h30);
		dr(10'h3FF);
		chk(rv, 24'h0);
		// software rerun of the keyed init pair
		hw(HREG_CMD, 24'h4);
		poll(0);
		@(posedge sys_clk);
		#1;
		chk(24'(tcfg), 24'(TIMING_OPTIMUM));
		$display("protection test done");
		@(posedge sys_clk);
		srst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		startup(50);
		summarize();
	end
	// cut a hung run short
	initial begin
		#100000;
		failures++;
		summarize();
	end
endmodule : meter_startup_and_gain_config_tb
`default_nettype wire
